// ===== design/tcp_pkg.sv
// package: register map, control layout and timing constants for the prescaled timer/counter
package tcp_pkg;
   // register byte offsets on the apb bus
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_LOW = 4'h4;
   localparam logic [3:0] ADDR_HIGH_BUF = 4'h8;
   localparam logic [3:0] ADDR_INT_CTRL = 4'hc;
   // timer_control field positions
   localparam int BIT_RUN = 7;
   localparam int BIT_NARROW = 6;
   localparam int BIT_SOURCE = 5;
   localparam int BIT_EDGE = 4;
   localparam int BIT_PS_ASSIGN = 3;
   localparam int BIT_RATIO_HI = 2;
   // interrupt_control field positions
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_OVF_EN = 5;
   localparam int BIT_OVF_FLAG = 2;
   // reset values
   localparam logic [7:0] RST_CONTROL = 8'hff;
   localparam logic [7:0] RST_HIGH_BUF = 8'h00;
   localparam logic [7:0] RST_LOW = 8'h00;
   localparam logic [7:0] RST_INT_CTRL = 8'h00;
   // timing: instruction cycle is four core cycles, write blanking two instruction cycles
   localparam logic [1:0] INSN_DIV_LAST = 2'h3;
   localparam logic [1:0] WRITE_BLANK = 2'h2;
endpackage : tcp_pkg

// ===== design/tcp_timer.sv
// module: prescaled 8/16-bit timer/counter with apb register access
//
// Function
// - timer mode, no prescaler: count advances once per instruction cycle
// - after a counter write, counting is blocked for two instruction cycles
// - counter mode counts edges of the external count input
// - edge select clear counts rising edges, set counts falling edges
// - external input is synchronised before its edges advance the count
// - 8-bit prescaler exists but is hidden from software
// - prescaler assign clear routes counting through ratio 1:2 to 1:256
// - counter write clears prescaler count, assignment unchanged
// - assignment and ratio may change while the timer runs
// - overflow flag sets on FFh to 00h or FFFFh to 0000h wrap
// - flag sets regardless of its enable or the global enable
// - interrupt request raised only while the overflow enable is set
// - timer halts during sleep, so overflow cannot wake the core
// - 16-bit mode: low byte read copies live high byte into buffer
// - 16-bit mode: low byte write loads live high byte from buffer
// - live high byte has no direct software path, only the buffer
// - control holds run, width, source, edge, assign, ratio; resets to ffh
`timescale 1ns/1ps
`default_nettype none
module tcp_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device pins and core status
   input wire logic external_count_input,
   input wire logic sleep_mode,
   output logic overflow_irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] timer_control;
   logic [7:0] count_low_byte;
   logic [7:0] count_live_high;
   logic [7:0] count_high_buffer;
   logic global_irq_enable;
   logic overflow_irq_enable;
   logic overflow_flag;
   logic [7:0] prescaler;
   logic [1:0] insn_div;
   logic [1:0] blank_cnt;
   logic [2:0] ext_sync;
   logic ext_prev;
   logic apb_access;
   logic wr_low;
   logic rd_low;
   logic insn_tick;
   logic ext_edge;
   logic source_tick;
   logic count_tick;
   logic ps_hit;
   logic overflow;

   function automatic logic [7:0] ratio_mask(input logic [2:0] code);
      // code n divides by 2^(n+1): tick when the low n+1 bits are all ones
      ratio_mask = 8'(({1'b0, 8'hff} << (4'(code) + 4'h1)) >> 9'h0) ^ 8'hff;
   endfunction : ratio_mask

   assign apb_access = psel && penable;
   assign wr_low = apb_access && pwrite && (paddr == tcp_pkg::ADDR_LOW);
   assign rd_low = apb_access && !pwrite && (paddr == tcp_pkg::ADDR_LOW);
   assign insn_tick = (insn_div == tcp_pkg::INSN_DIV_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // instruction-cycle enable; frozen in sleep like the rest of the core
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         insn_div <= 2'h0;
      else if (!sleep_mode)
         insn_div <= insn_div + 2'h1;

   // external pin: three flops, a change counts once stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ext_sync <= 3'h0;
         ext_prev <= 1'b0;
      end
      else
      begin
         ext_sync <= {ext_sync[1:0], external_count_input};
         if (ext_sync[2] == ext_sync[1])
            ext_prev <= ext_sync[2];
      end

   // edge polarity picks rising or falling of the filtered level
   assign ext_edge = (ext_sync[2] == ext_sync[1]) && (ext_sync[2] != ext_prev) &&
      (ext_sync[2] ^ timer_control[tcp_pkg::BIT_EDGE]);
   assign source_tick = timer_control[tcp_pkg::BIT_SOURCE] ? ext_edge : insn_tick;

   ////////////////////////////////////////////////////////////////////////////
   // write blanking counts instruction cycles after a counter write
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         blank_cnt <= 2'h0;
      else if (wr_low)
         blank_cnt <= tcp_pkg::WRITE_BLANK;
      else if (insn_tick && blank_cnt != 2'h0)
         blank_cnt <= blank_cnt - 2'h1;

   // prescaler: not mapped on the bus, ratio read live so changes apply at once
   assign ps_hit = ((prescaler & ratio_mask(timer_control[tcp_pkg::BIT_RATIO_HI:0])) ==
      ratio_mask(timer_control[tcp_pkg::BIT_RATIO_HI:0]));
   assign count_tick = timer_control[tcp_pkg::BIT_RUN] && !sleep_mode && blank_cnt == 2'h0 &&
      source_tick && (timer_control[tcp_pkg::BIT_PS_ASSIGN] || ps_hit);

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         prescaler <= 8'h00;
      else if (wr_low && !timer_control[tcp_pkg::BIT_PS_ASSIGN])
         prescaler <= 8'h00;
      else if (timer_control[tcp_pkg::BIT_PS_ASSIGN])
         prescaler <= 8'h00;
      else if (timer_control[tcp_pkg::BIT_RUN] && !sleep_mode && blank_cnt == 2'h0 && source_tick)
         prescaler <= ps_hit ? 8'h00 : prescaler + 8'h01;

   ////////////////////////////////////////////////////////////////////////////
   // counter; the live high byte is reachable only through the buffer
   assign overflow = count_tick && (count_low_byte == 8'hff) &&
      (timer_control[tcp_pkg::BIT_NARROW] || count_live_high == 8'hff);

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         count_low_byte <= tcp_pkg::RST_LOW;
         count_live_high <= tcp_pkg::RST_LOW;
      end
      else if (wr_low)
      begin
         count_low_byte <= pwdata[7:0];
         if (!timer_control[tcp_pkg::BIT_NARROW])
            count_live_high <= count_high_buffer;
      end
      else if (count_tick)
      begin
         count_low_byte <= count_low_byte + 8'h01;
         if (!timer_control[tcp_pkg::BIT_NARROW] && count_low_byte == 8'hff)
            count_live_high <= count_live_high + 8'h01;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         count_high_buffer <= tcp_pkg::RST_HIGH_BUF;
      else if (apb_access && pwrite && paddr == tcp_pkg::ADDR_HIGH_BUF)
         count_high_buffer <= pwdata[7:0];
      else if (rd_low && !timer_control[tcp_pkg::BIT_NARROW])
         count_high_buffer <= count_live_high;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         timer_control <= tcp_pkg::RST_CONTROL;
      else if (apb_access && pwrite && paddr == tcp_pkg::ADDR_CONTROL)
         timer_control <= pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         global_irq_enable <= 1'b0;
         overflow_irq_enable <= 1'b0;
         overflow_flag <= 1'b0;
      end
      else
      begin
         if (apb_access && pwrite && paddr == tcp_pkg::ADDR_INT_CTRL)
         begin
            global_irq_enable <= pwdata[tcp_pkg::BIT_GLOBAL_EN];
            overflow_irq_enable <= pwdata[tcp_pkg::BIT_OVF_EN];
            overflow_flag <= pwdata[tcp_pkg::BIT_OVF_FLAG] || overflow;
         end
         else if (overflow)
            overflow_flag <= 1'b1;
      end

   // request is the masked flag; global enable is left to the core
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         overflow_irq <= 1'b0;
      else
         overflow_irq <= overflow_flag && overflow_irq_enable;

   ////////////////////////////////////////////////////////////////////////////
   // apb: zero wait states, unmapped addresses read zero with pslverr
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr != tcp_pkg::ADDR_CONTROL && paddr != tcp_pkg::ADDR_LOW &&
            paddr != tcp_pkg::ADDR_HIGH_BUF && paddr != tcp_pkg::ADDR_INT_CTRL;
         prdata <= 32'h0;
         if (psel && !penable && !pwrite)
            unique case (paddr)
               tcp_pkg::ADDR_CONTROL: prdata <= {24'h0, timer_control};
               tcp_pkg::ADDR_LOW: prdata <= {24'h0, count_low_byte};
               tcp_pkg::ADDR_HIGH_BUF: prdata <= {24'h0, count_high_buffer};
               tcp_pkg::ADDR_INT_CTRL: prdata <= {24'h0, global_irq_enable, 1'b0, overflow_irq_enable,
                  2'h0, overflow_flag, 2'h0};
               default: prdata <= 32'h0;
            endcase
      end
endmodule : tcp_timer
`default_nettype wire

// ===== verif/tcp_timer_properties.sv
// checker: port-level properties of the prescaled timer/counter
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_properties (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb and pins
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic external_count_input,
   input wire logic sleep_mode,
   input wire logic overflow_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic ic_wr = psel && penable && pwrite && paddr == tcp_pkg::ADDR_INT_CTRL;
   chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
   chk_ready_once: assert property (pready |=> !pready) else $error("ready held");
   chk_err_unmapped: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
   chk_ok_mapped: assert property (pready && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
   chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
   chk_irq_masked: assert property (ic_wr && !pwdata[5] |=> ##1 !overflow_irq) else $error("irq unmasked");
   chk_irq_raise: assert property (ic_wr && pwdata[5] && pwdata[2] |=> ##1 overflow_irq) else $error("irq low");
   // three idle cycles rule out a late register write raising the request
   chk_sleep_quiet: assert property ((sleep_mode && !psel)[*3] |-> !$rose(overflow_irq)) else $error("sleep irq");
   cover property (ic_wr && pwdata[5]);
   cover property ($rose(overflow_irq));
   cover property (pready && pslverr);
endmodule : tcp_timer_properties
bind tcp_timer tcp_timer_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .external_count_input, .sleep_mode, .overflow_irq);
`default_nettype wire

// ===== verif/tcp_pin_model.sv
// partner: external count pin, one level change per request
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model (
   // clock and request
   input wire logic pclk,
   input wire logic presetn,
   input wire logic toggle_req,
   // pin
   output logic external_count_input
);
   // spacing is left to the caller, so slow and fast edges are both possible
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         external_count_input <= 1'b0;
      else if (toggle_req)
         external_count_input <= ~external_count_input;
   end
endmodule : tcp_pin_model
`default_nettype wire

// ===== verif/tb.sv
// testbench: apb scenarios for the prescaled timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_mode = 1'b0, tog = 1'b0;
   logic [3:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, pin, irq;
   logic [7:0] v;
   logic [15:0] exp_q[$];
   int err_total = 0, check_count = 0, seed = 51, n;
   tcp_timer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .external_count_input(pin), .sleep_mode, .overflow_irq(irq));
   tcp_pin_model pin_u (.pclk, .presetn, .toggle_req(tog), .external_count_input(pin));
   initial
   begin
      forever #20 pclk = ~pclk;
   end
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : cmp8
   task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int i;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1)
      begin
         err_total++;
         report_and_stop();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // mask in the upper byte lets a read ignore bits that depend on divider phase
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      exp_q.push_back({m, e});
      apb(1'b0, a, 8'h00);
   endtask : rd
   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
   endtask : tick
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite)
      begin
         cmp8("prdata", exp_q[0][7:0] & exp_q[0][15:8], prdata[7:0] & exp_q[0][15:8]);
         void'(exp_q.pop_front());
      end
   end
   ///////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(3);
      presetn <= 1'b1;
      rd(tcp_pkg::ADDR_CONTROL, 8'hff);
      rd(tcp_pkg::ADDR_HIGH_BUF, 8'h00);
      rd(4'h2, 8'h00);
      apb(1'b1, tcp_pkg::ADDR_CONTROL, 8'h08);
      repeat (3)
      begin
         v = 8'($random(seed));
         apb(1'b1, tcp_pkg::ADDR_HIGH_BUF, v);
         apb(1'b1, tcp_pkg::ADDR_LOW, ~v);
         apb(1'b1, tcp_pkg::ADDR_HIGH_BUF, 8'h00);
         tick(20);
         rd(tcp_pkg::ADDR_LOW, ~v);
         rd(tcp_pkg::ADDR_HIGH_BUF, v);
      end
      apb(1'b1, tcp_pkg::ADDR_CONTROL, 8'hc8);
      apb(1'b1, tcp_pkg::ADDR_LOW, 8'hfd);
      rd(tcp_pkg::ADDR_LOW, 8'hfd);
      tick(40);
      rd(tcp_pkg::ADDR_INT_CTRL, 8'h04, 8'h04);
      apb(1'b1, tcp_pkg::ADDR_INT_CTRL, 8'h00);
      apb(1'b1, tcp_pkg::ADDR_INT_CTRL, 8'h24);
      tick(2);
      cmp8("irq", 8'h01, {7'h0, irq});
      apb(1'b1, tcp_pkg::ADDR_INT_CTRL, 8'h04);
      tick(2);
      cmp8("irq", 8'h00, {7'h0, irq});
      apb(1'b1, tcp_pkg::ADDR_INT_CTRL, 8'h00);
      sleep_mode <= 1'b1;
      apb(1'b1, tcp_pkg::ADDR_LOW, 8'hfe);
      tick(40);
      rd(tcp_pkg::ADDR_LOW, 8'hfe);
      sleep_mode <= 1'b0;
      apb(1'b1, tcp_pkg::ADDR_CONTROL, 8'h08);
      apb(1'b1, tcp_pkg::ADDR_HIGH_BUF, 8'hff);
      apb(1'b1, tcp_pkg::ADDR_LOW, 8'hff);
      apb(1'b1, tcp_pkg::ADDR_CONTROL, 8'h88);
      tick(40);
      rd(tcp_pkg::ADDR_LOW, 8'h00, 8'hf0);
      rd(tcp_pkg::ADDR_HIGH_BUF, 8'h00);
      rd(tcp_pkg::ADDR_INT_CTRL, 8'h04, 8'h04);
      for (n = 0; n < 2; n++)
      begin
         apb(1'b1, tcp_pkg::ADDR_CONTROL, {3'h7, n[0], 4'h8});
         apb(1'b1, tcp_pkg::ADDR_LOW, 8'h00);
         tick(12);
         repeat (3)
         begin
            tog <= 1'b1;
            tick(1);
            tog <= 1'b0;
            tick(8);
         end
         rd(tcp_pkg::ADDR_LOW, 8'h02);
      end
      for (n = 0; n < 8; n++)
      begin
         apb(1'b1, tcp_pkg::ADDR_CONTROL, {5'h18, n[2:0]});
         apb(1'b1, tcp_pkg::ADDR_LOW, 8'h00);
         tick(8 + (8 << n));
         rd(tcp_pkg::ADDR_LOW, 8'h01, 8'hfe);
      end
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
